// file: rtl/cpld_power_down_and_global_routing.sv
// Chip-level power, pin keeper, slew, global control and bus routing
//
// Behaviour
// R1: Power-down when enabled and pin high
// R2: Power-down freezes state and enabled outputs
// R3: Pin activity ignored until pin low
// R4: Enabled power-down pin is not logic
// R5: Power-down cell still feeds foldback, cascade
// R6: Automatic standby on inactivity, wake on activity
// R7: Keeper holds last driven pin level
// R8: Keeper selectable, off means no holding
// R9: Per-output slew, default slow
// R10: Dedicated inputs: logic, clock, clear, enable
// R11: Each cell selects global controls independently
// R12: Pins and feedback on global bus
// R13: Foldback terms reach all region cells
// R14: Four cascade chains, forty product terms
// R15: Power-down disabled: pin is ordinary logic
module cpld_power_down_and_global_routing (
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    // Avalon-MM slave
    input  wire logic [5:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    // Device pins
    input  wire logic                    power_down_pin,
    input  wire logic                    global_clear_pin,
    input  wire logic                    output_enable_pin_one,
    input  wire logic                    output_enable_pin_two,
    input  wire logic [3:0]              ded_in,
    input  wire logic [31:0]             io_in,
    input  wire logic [31:0]             io_in_driven,
    output logic      [31:0]             io_out,
    output logic      [31:0]             io_oe_n,
    output logic      [31:0]             io_keep,
    output logic      [31:0]             io_slew_fast,
    // Macrocell side
    input  wire logic [31:0]             cell_fb,
    input  wire logic [31:0]             cell_foldback,
    input  wire logic [31:0]             cell_sum,
    input  wire logic [31:0]             cell_cas_en,
    input  wire logic [31:0]             cell_oe_req,
    output logic      [67:0]             global_bus,
    output logic      [31:0]             region_bus,
    output logic      [31:0]             cascade_out,
    output logic      [31:0]             cell_clk_en,
    output logic      [31:0]             cell_clear,
    output logic                         logic_hold,
    output logic      [2:0]              power_state
);
    // Synchronised pin inputs
    logic [31:0] io_s;
    logic [31:0] drv_s;
    logic [3:0]  ded_s;
    logic        pd_s;
    logic        global_clear_pin_s;
    logic        oe1_s;
    logic        oe2_s;
    logic [31:0] casc;

    pin_sync #(.W(32)) u_sync_io (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in (io_in),
        .sync_out (io_s)
    );
    pin_sync #(.W(32)) u_sync_drv (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in (io_in_driven),
        .sync_out (drv_s)
    );
    pin_sync #(.W(8)) u_sync_ctl (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in ({ded_in, power_down_pin, global_clear_pin,
                    output_enable_pin_one, output_enable_pin_two}),
        .sync_out ({ded_s, pd_s, global_clear_pin_s, oe1_s, oe2_s})
    );

    // Four cascade chains of neighbouring cells
    for (genvar c = 0; c < cpld_ctrl_pkg::NUM_CHAINS; c++) begin : g_chain
        cascade_chain #(.LEN(cpld_ctrl_pkg::CHAIN_LEN)) u_chain (
            .cell_sum  (cell_sum[c*8 +: 8]),
            .cas_en    (cell_cas_en[c*8 +: 8]),
            .chain_out (casc[c*8 +: 8])
        ); // R14
    end

    typedef struct packed {
        logic [31:0]             config_r;
        logic [31:0]             keeper;
        logic [31:0]             slew;
        logic [31:0]             dedmode;
        logic [31:0]             cellen;
        logic [31:0]             cellclr;
        logic [31:0]             celloe;
        cpld_ctrl_pkg::pwr_state_t pwr;
        logic [7:0]              idle;
        logic [31:0]             io_last;
        logic [3:0]              ded_last;
        logic [31:0]             pin_view;
        logic [3:0]              ded_view;
        logic [31:0]             fb_view;
        logic [31:0]             keep_lvl;
        logic [31:0]             out;
        logic [31:0]             oe_n;
        logic [31:0]             keep_out;
        logic [31:0]             slew_out;
        logic [67:0]             gbus;
        logic [31:0]             rbus;
        logic [31:0]             cas;
        logic [31:0]             clk_en;
        logic [31:0]             clr;
        logic                    hold;
        logic                    ack;
        logic [31:0]             rdata;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    // Scratch values of the combinational process
    logic        pd_active;
    logic        activity;
    logic        g_clk;
    logic        g_clr;
    logic        g_oe;
    logic [31:0] pd_mask;
    logic [31:0] pin_eff;

    always_comb begin
        next_st   = st;
        pd_active = 1'b0;
        activity  = 1'b0;
        g_clk     = 1'b0;
        g_clr     = 1'b0;
        g_oe      = 1'b0;
        pd_mask   = 32'h0000_0000;
        pin_eff   = 32'h0000_0000;

        // Register access, one wait cycle then acknowledge
        next_st.ack = 1'b0;
        // Write lands at the edge the master sees waitrequest low
        if (avs_write && st.ack) begin
            case (avs_address[5:2])
                cpld_ctrl_pkg::REG_CONFIG:  next_st.config_r =
                    avs_writedata & 32'h0000_0003;
                cpld_ctrl_pkg::REG_KEEPER:  next_st.keeper  = avs_writedata;
                cpld_ctrl_pkg::REG_SLEW:    next_st.slew    = avs_writedata;
                cpld_ctrl_pkg::REG_DEDMODE: next_st.dedmode =
                    avs_writedata & 32'h0000_00FF;
                cpld_ctrl_pkg::REG_CELLEN:  next_st.cellen  = avs_writedata;
                cpld_ctrl_pkg::REG_CELLCLR: next_st.cellclr = avs_writedata;
                cpld_ctrl_pkg::REG_CELLOE:  next_st.celloe  = avs_writedata;
                default: ;
            endcase
        end
        if ((avs_read || avs_write) && !st.ack) begin
            next_st.ack = 1'b1;
            case (avs_address[5:2])
                cpld_ctrl_pkg::REG_CONFIG:  next_st.rdata = st.config_r;
                cpld_ctrl_pkg::REG_KEEPER:  next_st.rdata = st.keeper;
                cpld_ctrl_pkg::REG_SLEW:    next_st.rdata = st.slew;
                cpld_ctrl_pkg::REG_DEDMODE: next_st.rdata = st.dedmode;
                cpld_ctrl_pkg::REG_CELLEN:  next_st.rdata = st.cellen;
                cpld_ctrl_pkg::REG_CELLCLR: next_st.rdata = st.cellclr;
                cpld_ctrl_pkg::REG_CELLOE:  next_st.rdata = st.celloe;
                cpld_ctrl_pkg::REG_STATUS:  next_st.rdata =
                    {29'h0000_0000, st.pwr};
                default:                    next_st.rdata = 32'h0000_0000;
            endcase
        end

        // Power-down pin counts only when the option is enabled
        pd_active = st.config_r[cpld_ctrl_pkg::CFG_PD_EN] & pd_s; // R1 R15
        pd_mask = st.config_r[cpld_ctrl_pkg::CFG_PD_EN] ?
            (32'h0000_0001 << cpld_ctrl_pkg::PD_CELL) : 32'h0000_0000;

        // Inactivity detection on pins and feedback
        activity = (io_s != st.io_last) || (ded_s != st.ded_last)
                   || (cell_fb != st.fb_view);
        next_st.io_last  = io_s;
        next_st.ded_last = ded_s;

        case (st.pwr)
            cpld_ctrl_pkg::PWR_RUN: begin
                if (pd_active) begin
                    next_st.pwr = cpld_ctrl_pkg::PWR_DOWN; // R1
                end else if (activity) begin
                    next_st.idle = 8'h00;
                end else if (st.idle == cpld_ctrl_pkg::IDLE_CYCLES) begin
                    next_st.pwr = cpld_ctrl_pkg::PWR_STANDBY; // R6
                end else begin
                    next_st.idle = st.idle + 8'h01;
                end
            end
            cpld_ctrl_pkg::PWR_STANDBY: begin
                if (pd_active) begin
                    next_st.pwr = cpld_ctrl_pkg::PWR_DOWN;
                end else if (activity) begin
                    next_st.pwr  = cpld_ctrl_pkg::PWR_RUN; // R6
                    next_st.idle = 8'h00;
                end
            end
            cpld_ctrl_pkg::PWR_DOWN: begin
                if (!pd_active) begin
                    next_st.pwr  = cpld_ctrl_pkg::PWR_RUN; // R3
                    next_st.idle = 8'h00;
                end
            end
            default: next_st.pwr = cpld_ctrl_pkg::PWR_RUN;
        endcase

        next_st.hold = (next_st.pwr == cpld_ctrl_pkg::PWR_DOWN); // R2

        // Keeper: driven pins track, released pins with keeper on hold last level, others read low
        for (int i = 0; i < 32; i++) begin
            if (drv_s[i]) begin
                next_st.keep_lvl[i] = io_s[i]; // R7
            end
            if (drv_s[i]) begin
                pin_eff[i] = io_s[i];
            end else if (st.config_r[cpld_ctrl_pkg::CFG_KEEP_EN]
                         && st.keeper[i]) begin
                pin_eff[i] = st.keep_lvl[i]; // R7
            end else begin
                pin_eff[i] = 1'b0; // R8
            end
        end
        next_st.keep_out = st.config_r[cpld_ctrl_pkg::CFG_KEEP_EN] ?
            st.keeper : 32'h0000_0000; // R8
        next_st.slew_out = st.slew; // R9

        // Dedicated inputs as logic or global controls
        for (int d = 0; d < 4; d++) begin
            case (st.dedmode[2*d +: 2])
                cpld_ctrl_pkg::DED_CLOCK: g_clk = g_clk | ded_s[d]; // R10
                cpld_ctrl_pkg::DED_CLEAR: g_clr = g_clr | ded_s[d]; // R10
                cpld_ctrl_pkg::DED_OE:    g_oe  = g_oe  | ded_s[d]; // R10
                default: ;
            endcase
        end
        g_clr = g_clr | !global_clear_pin_s;
        g_oe  = g_oe | !oe1_s | !oe2_s;

        // Frozen while powered down: pins ignored, logic held
        if (next_st.hold) begin
            next_st.io_last  = st.io_last; // R3
            next_st.ded_last = st.ded_last;
            next_st.keep_lvl = st.keep_lvl;
        end else begin
            next_st.pin_view = pin_eff & ~pd_mask; // R4
            next_st.ded_view = ded_s;
            next_st.fb_view  = cell_fb;
            next_st.gbus     = {ded_s, cell_fb, pin_eff & ~pd_mask}; // R12
            next_st.rbus     = cell_foldback; // R13 R5
            next_st.cas      = casc; // R14 R5
            next_st.clk_en   = st.cellen & {32{g_clk}}; // R11
            next_st.clr      = st.cellclr & {32{g_clr}}; // R11
            next_st.oe_n     = ~((st.celloe & {32{g_oe}}) | cell_oe_req)
                               | pd_mask; // R4 R11
            next_st.out      = cell_fb & ~pd_mask;
        end
        // R2: out and oe_n keep their values while held
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st          <= '0;
            st.config_r <= cpld_ctrl_pkg::CONFIG_RST;
            st.keeper   <= cpld_ctrl_pkg::KEEPER_RST;
            st.slew     <= cpld_ctrl_pkg::SLEW_RST;
            st.pwr      <= cpld_ctrl_pkg::PWR_RUN;
            st.oe_n     <= 32'hFFFF_FFFF;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = !st.ack;
    assign io_out          = st.out;
    assign io_oe_n         = st.oe_n;
    assign io_keep         = st.keep_out;
    assign io_slew_fast    = st.slew_out;
    assign global_bus      = st.gbus;
    assign region_bus      = st.rbus;
    assign cascade_out     = st.cas;
    assign cell_clk_en     = st.clk_en;
    assign cell_clear      = st.clr;
    assign logic_hold      = st.hold;
    assign power_state     = st.pwr;
endmodule : cpld_power_down_and_global_routing

// file: rtl/cpld_ctrl_pkg.sv
// Shared constants and carrier types for the device control block
package cpld_ctrl_pkg;
    localparam int NUM_CELLS      = 32;
    localparam int NUM_REGION     = 16;
    localparam int NUM_DED        = 4;
    localparam int NUM_CHAINS     = 4;
    localparam int CHAIN_LEN      = NUM_CELLS / NUM_CHAINS;
    localparam int CELL_TERMS     = 5;
    localparam int CHAIN_MAX_PT   = 40;
    localparam int GBUS_W         = NUM_CELLS + NUM_CELLS + NUM_DED;
    localparam int PD_CELL        = 31;
    // Idle cycles before standby; kept small on purpose
    localparam logic [7:0] IDLE_CYCLES = 8'h10;

    // Register map (word addresses, byte address = 4 * index)
    localparam logic [3:0] REG_CONFIG  = 4'h0;
    localparam logic [3:0] REG_KEEPER  = 4'h1;
    localparam logic [3:0] REG_SLEW    = 4'h2;
    localparam logic [3:0] REG_DEDMODE = 4'h3;
    localparam logic [3:0] REG_CELLEN  = 4'h4;
    localparam logic [3:0] REG_CELLCLR = 4'h5;
    localparam logic [3:0] REG_CELLOE  = 4'h6;
    localparam logic [3:0] REG_STATUS  = 4'h7;

    // Config and status fields
    localparam int CFG_PD_EN   = 0;
    localparam int CFG_KEEP_EN = 1;
    localparam int ST_PD       = 0;
    localparam int ST_STANDBY  = 1;

    // Reset values: slow slew everywhere, keepers on, power-down off
    localparam logic [31:0] CONFIG_RST = 32'h0000_0002;
    localparam logic [31:0] SLEW_RST   = 32'h0000_0000;
    localparam logic [31:0] KEEPER_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] ZERO_RST   = 32'h0000_0000;

    // Dedicated input roles
    localparam logic [1:0] DED_LOGIC = 2'h0;
    localparam logic [1:0] DED_CLOCK = 2'h1;
    localparam logic [1:0] DED_CLEAR = 2'h2;
    localparam logic [1:0] DED_OE    = 2'h3;

    typedef enum logic [2:0] {
        PWR_RUN     = 3'b001,
        PWR_STANDBY = 3'b010,
        PWR_DOWN    = 3'b100
    } pwr_state_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [5:0]  address;
        logic [31:0] writedata;
    } av_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } av_rsp_t;

    typedef struct packed {
        logic [NUM_CELLS-1:0] o;
        logic [NUM_CELLS-1:0] oe_n;
    } pin_drive_t;
endpackage : cpld_ctrl_pkg

// file: rtl/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // Shift chain; a change counts once stages two and three agree
    always_comb begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.q;
endmodule : pin_sync

// file: rtl/cascade_chain.sv
// One cascade chain: OR of the cell sum terms along neighbouring cells
module cascade_chain #(
    parameter int LEN = 8
) (
    input  wire logic [LEN-1:0] cell_sum,
    input  wire logic [LEN-1:0] cas_en,
    output logic      [LEN-1:0] chain_out
);
    // Each cell after the first ORs its own sum with the cascade from its neighbour when cas_en is set
    always_comb begin
        chain_out[0] = cell_sum[0];
        for (int i = 1; i < LEN; i++) begin
            chain_out[i] = cell_sum[i] | (cas_en[i] & chain_out[i-1]);
        end
    end
endmodule : cascade_chain

// file: bench/cpld_pd_checker.sv
// Port checks for the power and routing control block
module cpld_pd_checker (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] io_out,
    input  wire logic [31:0] io_oe_n,
    input  wire logic [31:0] io_slew_fast,
    input  wire logic [67:0] global_bus,
    input  wire logic        logic_hold,
    input  wire logic [2:0]  power_state
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // Bus answer comes one cycle after the request, for one cycle
    a_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer longer than one cycle");

    // Power state coding and hold flag agree
    a_state_hot: assert property ($onehot(power_state))
        else $error("power state not one-hot");
    a_hold_state: assert property (
        logic_hold == (power_state == cpld_ctrl_pkg::PWR_DOWN))
        else $error("hold flag and power state disagree");

    // Frozen outputs and bus while powered down, exit to run, slew changes only after a write
    a_freeze_pins: assert property (logic_hold ##1 logic_hold
        |-> $stable(io_out) && $stable(io_oe_n))
        else $error("outputs moved while powered down");
    a_freeze_bus: assert property (logic_hold ##1 logic_hold
        |-> $stable(global_bus))
        else $error("global bus moved while powered down");
    a_wake_run: assert property (
        $fell(logic_hold) |-> power_state == cpld_ctrl_pkg::PWR_RUN)
        else $error("power-down exit not to run");
    a_slew_write: assert property (
        !$stable(io_slew_fast) |-> $past(avs_write) || $past(avs_write, 2))
        else $error("slew changed without a write");

    // Main scenarios
    cover property ($rose(logic_hold));
    cover property (power_state == cpld_ctrl_pkg::PWR_STANDBY
        ##1 power_state == cpld_ctrl_pkg::PWR_RUN);
    cover property (avs_read && !avs_waitrequest);
endmodule : cpld_pd_checker

bind cpld_power_down_and_global_routing cpld_pd_checker chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .io_out(io_out), .io_oe_n(io_oe_n), .io_slew_fast(io_slew_fast),
    .global_bus(global_bus), .logic_hold(logic_hold),
    .power_state(power_state));

// file: bench/board_model.sv
// Board logic model driving the device pins
module board_model (
    input  wire logic        ref_clk,
    input  wire logic [31:0] lvl,
    input  wire logic [31:0] drv,
    input  wire logic [7:0]  ctl,
    output logic      [31:0] io_in,
    output logic      [31:0] io_in_driven,
    output logic      [7:0]  pins
);
    logic [31:0] last = 32'h0000_0000;

    // Quiet pins at time zero
    initial begin
        io_in = 32'h0000_0000;
        io_in_driven = 32'h0000_0000;
        pins = 8'h0E;
    end

    // Released lines show the inverse of their last driven level
    always @(posedge ref_clk) begin
        last <= (lvl & drv) | (last & ~drv);
        io_in <= (lvl & drv) | (~last & ~drv);
        io_in_driven <= drv;
        pins <= ctl;
    end
endmodule : board_model

// file: bench/tb_cpld_power_down_and_global_routing.sv
// Self-checking bench for the power and routing control block
module tb_cpld_power_down_and_global_routing;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RV [8] = '{cpld_ctrl_pkg::CONFIG_RST,
        cpld_ctrl_pkg::KEEPER_RST, cpld_ctrl_pkg::SLEW_RST, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001};
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] lvl = 32'h0000_0000;
    logic [31:0] drv = 32'h0000_0000;
    logic [7:0]  ctl = 8'h0E;
    logic [31:0] cell_fb = 32'h0000_0000;
    logic [31:0] cell_foldback = 32'h0000_0000;
    logic [31:0] cell_sum = 32'h0000_0000;
    logic [31:0] cell_cas_en = 32'h0000_0000;
    logic [31:0] cell_oe_req = 32'h0000_0000;
    logic [31:0] io_in, io_in_driven, avs_readdata, io_keep, io_slew_fast;
    logic [31:0] region_bus, cascade_out, cell_clear, io_out;
    logic [67:0] global_bus;
    logic [7:0]  pins;
    logic [2:0]  power_state;
    logic        avs_waitrequest, logic_hold;
    logic [31:0] seed = 32'h0000_0049;
    logic [31:0] a, b, c, f, s, k;
    logic [3:0]  d;
    logic [31:0] expq [$];
    int          fail_count = 0;
    int          compares = 0;
    string       pn [9] = '{"global_bus", "region_bus", "cascade_out",
        "power_state", "io_keep", "io_slew_fast", "cell_clear", "logic_hold",
        "io_out"};

    board_model brd (.ref_clk, .lvl, .drv, .ctl, .io_in, .io_in_driven,
        .pins);
    cpld_power_down_and_global_routing uut (.ref_clk, .reset_n,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .power_down_pin(pins[0]),
        .global_clear_pin(pins[1]), .output_enable_pin_one(pins[2]),
        .output_enable_pin_two(pins[3]), .ded_in(pins[7:4]), .io_in,
        .io_in_driven, .io_out, .io_oe_n(), .io_keep, .io_slew_fast,
        .cell_fb, .cell_foldback, .cell_sum, .cell_cas_en, .cell_oe_req,
        .global_bus, .region_bus, .cascade_out, .cell_clk_en(), .cell_clear,
        .logic_hold, .power_state);

    always #5 ref_clk = ~ref_clk;

    // Output selector and random source
    function automatic logic [67:0] pick(input int i);
        case (i)
            0: return global_bus;
            1: return 68'(region_bus);
            2: return 68'(cascade_out);
            3: return 68'(power_state);
            4: return 68'(io_keep);
            5: return 68'(io_slew_fast);
            6: return 68'(cell_clear);
            7: return 68'(logic_hold);
            default: return 68'(io_out);
        endcase
    endfunction : pick
    function logic [31:0] rnd();
        for (int i = 0; i < 32; i++) begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        end
        return seed;
    endfunction : rnd

    // Verdict and comparisons
    task automatic stop_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk_port(input int i, input logic [67:0] e);
        compares++;
        if (pick(i) !== e) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", pn[i], e, pick(i));
        end
    endtask : chk_port
    task automatic chk_rd(input logic [31:0] e);
        compares++;
        if (avs_readdata !== e) begin
            fail_count++;
            $display("ERROR readdata exp %h got %h", e, avs_readdata);
        end
    endtask : chk_rd
    task automatic wait_val(input int i, input logic [67:0] e);
        int n;
        n = 0;
        while (pick(i) !== e && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
        chk_port(i, e);
        if (n >= 60) begin
            stop_test();
        end
    endtask : wait_val
    task automatic end_test(input string t);
        $display("test %s done", t);
    endtask : end_test

    // Bus master: hold request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] r,
                       input logic [31:0] v, input logic [31:0] e);
        int n;
        n = 0;
        avs_read <= !w;
        avs_write <= w;
        avs_address <= {r, 2'b00};
        avs_writedata <= v;
        if (!w) begin
            expq.push_back(e);
        end
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
        if (n >= 50) begin
            fail_count++;
            stop_test();
        end
    endtask : bus
    task automatic wrd(input logic [3:0] r, input logic [31:0] v);
        bus(1'b1, r, v, 32'h0000_0000);
        bus(1'b0, r, 32'h0000_0000, v);
    endtask : wrd

    // Read answers against the oldest expectation
    always @(posedge ref_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            chk_rd(expq.pop_front());
        end
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 7; i >= 0; i--) begin
            bus(1'b0, 4'(i), 32'h0000_0000, RV[i]);
        end
        bus(1'b1, 4'h8, rnd(), 32'h0000_0000);
        bus(1'b0, 4'h8, 32'h0000_0000, 32'h0000_0000);
        wait_val(4, 68'(cpld_ctrl_pkg::KEEPER_RST));
        wait_val(5, 68'h0);
        end_test("reset values");
        k = rnd();
        a = rnd();
        c = rnd();
        wrd(cpld_ctrl_pkg::REG_KEEPER, k);
        wrd(cpld_ctrl_pkg::REG_SLEW, a);
        wrd(cpld_ctrl_pkg::REG_DEDMODE, 32'h0000_0000);
        wrd(cpld_ctrl_pkg::REG_CELLEN, rnd());
        wrd(cpld_ctrl_pkg::REG_CELLCLR, c);
        wrd(cpld_ctrl_pkg::REG_CELLOE, rnd());
        wait_val(4, 68'(k));
        wait_val(5, 68'(a));
        end_test("registers");
        for (int i = 0; i < 3; i++) begin
            a = rnd();
            b = rnd();
            f = rnd();
            s = rnd();
            d = 4'(rnd());
            lvl <= a;
            drv <= 32'hFFFF_FFFF;
            ctl <= {d, 4'hE};
            cell_fb <= b;
            cell_foldback <= f;
            cell_sum <= s;
            wait_val(0, {d, b, a});
            wait_val(1, 68'(f));
            wait_val(2, 68'(s));
        end
        end_test("routing");
        drv <= 32'h0000_0000;
        wait_val(0, {d, b, a & k});
        bus(1'b1, cpld_ctrl_pkg::REG_CONFIG, 32'h0000_0000, 32'h0000_0000);
        wait_val(0, {d, b, 32'h0000_0000});
        end_test("keeper");
        ctl <= {d, 4'hC};
        wait_val(6, 68'(c));
        ctl <= {d, 4'hF};
        wait_val(6, 68'h0);
        repeat (12) @(posedge ref_clk);
        chk_port(7, 68'h0);
        ctl <= {d, 4'hE};
        end_test("controls");
        a = rnd() & 32'h7FFF_FFFF;
        lvl <= a;
        drv <= 32'hFFFF_FFFF;
        wait_val(0, {d, b, a});
        bus(1'b1, cpld_ctrl_pkg::REG_CONFIG, 32'h0000_0003, 32'h0000_0000);
        f = rnd();
        lvl <= a | 32'h8000_0000;
        cell_foldback <= f;
        wait_val(1, 68'(f));
        repeat (12) @(posedge ref_clk);
        chk_port(0, {d, b, a});
        ctl <= {d, 4'hF};
        wait_val(3, 68'(cpld_ctrl_pkg::PWR_DOWN));
        k = b;
        b = rnd();
        s = rnd() & 32'h7FFF_FFFF;
        lvl <= s;
        cell_fb <= b;
        repeat (12) @(posedge ref_clk);
        chk_port(0, {d, k, a});
        chk_port(7, 68'h1);
        chk_port(8, 68'(k & 32'h7FFF_FFFF));
        ctl <= {d, 4'hE};
        wait_val(0, {d, b, s});
        wait_val(3, 68'(cpld_ctrl_pkg::PWR_STANDBY));
        lvl <= ~s;
        wait_val(3, 68'(cpld_ctrl_pkg::PWR_RUN));
        end_test("power");
        stop_test();
    end
endmodule : tb_cpld_power_down_and_global_routing
